// ### common/timer_pkg.sv
// Notes on behaviour
// - control resets to all ones; run bit clear stops
// - width bit: one 8-bit, zero 16-bit
// - timer mode counts each instruction cycle
// - low-byte write holds counting two cycles
// - counter mode: rising edge, or falling if set
// - external pin synchronised before it counts
// - prescaler 8-bit, hidden from software
// - bypass bit zero routes through prescaler
// - ratio field divides by two power n+1
// - count write clears prescaler, keeps assignment
// - assignment may change while timer runs
// - wrap to zero sets overflow flag
// - request raised only while mask set
// - timer halted while processor sleeps
// - low read in 16-bit mode snapshots high byte to buffer
// - live high byte reachable only through buffer
// - low write loads high byte from buffer
// - buffer resets zero; low byte keeps value
package timer_pkg;
  localparam logic [11:0] ctrl_addr    = 12'h000;
  localparam logic [11:0] low_addr     = 12'h004;
  localparam logic [11:0] high_addr    = 12'h008;
  localparam logic [11:0] irq_addr     = 12'h00c;
  localparam logic [7:0]  ctrl_reset   = 8'hff;
  localparam logic [7:0]  high_reset   = 8'h00;
  localparam int          run_pos      = 7;
  localparam int          width_pos    = 6;
  localparam int          source_pos   = 5;
  localparam int          edge_pos     = 4;
  localparam int          bypass_pos   = 3;
  localparam int          flag_pos     = 0;
  localparam int          mask_pos     = 1;
  localparam logic [1:0]  hold_cycles  = 2'h2;

  typedef struct packed {
    logic       run;
    logic       width8;
    logic       ext_src;
    logic       fall_edge;
    logic       bypass;
    logic [2:0] ratio;
  } ctrl_s;
endpackage

// ### rtl/timer_counter.sv
`timescale 1ns/1ps
module timer_counter (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_count_pin,
  input  wire logic        sleep,
  output logic             overflow_irq
);
  import timer_pkg::*;

  ctrl_s       ctrl_r;
  logic [7:0]  low_r;
  logic [7:0]  live_high_r;
  logic [7:0]  high_buf_r;
  logic [7:0]  presc_r;
  logic [1:0]  hold_r;
  logic        flag_r;
  logic        mask_r;
  logic        sync1_r;
  logic        sync2_r;
  logic        sync3_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        irq_r;

  // bus decode; response in the access phase, one wait state
  wire access   = psel && penable && !pready_r;
  wire wr       = access && pwrite;
  wire rd       = access && !pwrite;
  wire hit_ctrl = paddr == ctrl_addr;
  wire hit_low  = paddr == low_addr;
  wire hit_high = paddr == high_addr;
  wire hit_irq  = paddr == irq_addr;
  wire mapped   = hit_ctrl || hit_low || hit_high || hit_irq;
  wire wr_low   = wr && hit_low;
  wire rd_low   = rd && hit_low;

  // external pin edges: sync2 and sync3 are both settled copies
  wire rise     = sync2_r && !sync3_r;
  wire fall     = !sync2_r && sync3_r;
  wire ext_tick = ctrl_r.fall_edge ? fall : rise;
  wire src_tick = ctrl_r.ext_src ? ext_tick : 1'b1;

  // count enable: sleep and low writes freeze the whole path
  wire active   = ctrl_r.run && !sleep && hold_r == 2'h0;
  wire [7:0] presc_nxt = presc_r + 8'h01;

  // tap bit n falls once per 2^(n+1) increments of the prescaler
  function automatic logic tap_falls(input logic [7:0] cur,
                                     input logic [7:0] nxt,
                                     input logic [2:0] n);
    tap_falls = cur[n] && !nxt[n];
  endfunction

  // divide by 2^(n+1): tap bit n toggles from one to zero
  wire presc_tc = tap_falls(presc_r, presc_nxt, ctrl_r.ratio);
  wire inc      = active && src_tick && (ctrl_r.bypass || presc_tc);

  wire [15:0] cnt_nxt  = {live_high_r, low_r} + 16'h0001;
  wire        wrap8    = low_r == 8'hff;
  wire        wrap16   = {live_high_r, low_r} == 16'hffff;
  wire        wrap     = inc && (ctrl_r.width8 ? wrap8 : wrap16);

  // read mux; the live high byte is never selected
  wire [7:0] rd_byte =
    hit_ctrl ? ctrl_r :
    hit_low  ? low_r :
    hit_high ? high_buf_r :
    hit_irq  ? {6'h00, mask_r, flag_r} : 8'h00;

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= ctrl_reset;
    end else if (wr && hit_ctrl) begin
      ctrl_r <= pwdata[7:0];
    end
  end

  // prescaler: cleared on count write, bit assignment untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= 8'h00;
    end else if (wr_low || ctrl_r.bypass) begin
      presc_r <= 8'h00;
    end else if (active && src_tick) begin
      presc_r <= presc_nxt;
    end
  end

  // low byte; left unreset as it keeps its value across resets
  always_ff @(posedge pclk) begin
    if (wr_low) begin
      low_r <= pwdata[7:0];
    end else if (inc) begin
      low_r <= cnt_nxt[7:0];
    end
  end

  // live high byte: carry only in 16-bit mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_high_r <= 8'h00;
    end else if (wr_low) begin
      live_high_r <= high_buf_r;
    end else if (inc && !ctrl_r.width8) begin
      live_high_r <= cnt_nxt[15:8];
    end
  end

  // high buffer: written by software, snapshot on low read in 16-bit mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_buf_r <= high_reset;
    end else if (wr && hit_high) begin
      high_buf_r <= pwdata[7:0];
    end else if (rd_low && !ctrl_r.width8) begin
      high_buf_r <= live_high_r;
    end
  end

  // two-cycle increment hold after a low-byte write; reset also holds,
  // so the unreset low byte keeps its value through and just after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= hold_cycles;
    end else if (wr_low) begin
      hold_r <= hold_cycles;
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end
  end

  // pin synchroniser plus one stage for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= external_count_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // overflow flag: set beats a simultaneous software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
      mask_r <= 1'b0;
    end else begin
      if (wrap) begin
        flag_r <= 1'b1;
      end else if (wr && hit_irq) begin
        flag_r <= pwdata[flag_pos];
      end
      if (wr && hit_irq) begin
        mask_r <= pwdata[mask_pos];
      end
    end
  end

  // registered request, gated by mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (flag_r || wrap) && mask_r;
    end
  end

  // apb answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= access;
      pslverr_r <= access && !mapped;
      prdata_r  <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign overflow_irq = irq_r;

  // checks
  // two quiet cycles after a count write
  sequence s_two_quiet;
    !inc ##1 !inc;
  endsequence

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      wr_low |=> s_two_quiet;
  endproperty
  a_hold: assert property (p_hold) else $error("count moved during hold");

  property p_wrap_flag;
    @(posedge pclk) disable iff (!presetn)
      wrap |=> flag_r;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("flag not set");

  property p_mask;
    @(posedge pclk) disable iff (!presetn)
      !mask_r |=> !irq_r;
  endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");

  property p_sleep;
    @(posedge pclk) disable iff (!presetn)
      sleep |-> !inc;
  endproperty
  a_sleep: assert property (p_sleep) else $error("count in sleep");

  property p_snap;
    @(posedge pclk) disable iff (!presetn)
      rd_low && !ctrl_r.width8 && !(wr && hit_high) |=> high_buf_r == $past(live_high_r);
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot lost");

  property p_load;
    @(posedge pclk) disable iff (!presetn)
      wr_low |=> live_high_r == $past(high_buf_r) && low_r == $past(pwdata[7:0]);
  endproperty
  a_load: assert property (p_load) else $error("16-bit load wrong");

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
      !ctrl_r.run |-> !inc;
  endproperty
  a_stop: assert property (p_stop) else $error("count while stopped");

  property p_eight;
    @(posedge pclk) disable iff (!presetn)
      ctrl_r.width8 && !wr_low |=> live_high_r == $past(live_high_r);
  endproperty
  a_eight: assert property (p_eight) else $error("high moved in 8-bit");

  property p_presc_clr;
    @(posedge pclk) disable iff (!presetn)
      wr_low |=> presc_r == 8'h00;
  endproperty
  a_presc_clr: assert property (p_presc_clr) else $error("prescaler kept");

  // a pending hold always gates the count
  property p_hold_gate;
    @(posedge pclk) disable iff (!presetn)
      hold_r != 2'h0 |-> !inc;
  endproperty
  a_hold_gate: assert property (p_hold_gate) else $error("count during hold");

  // each count step adds exactly one
  property p_step;
    @(posedge pclk) disable iff (!presetn)
      inc && !wr_low |=> low_r == $past(low_r) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("low byte step wrong");

  // carry into the live high byte in 16-bit mode
  property p_carry;
    @(posedge pclk) disable iff (!presetn)
      inc && !wr_low && !ctrl_r.width8 && wrap8 |=> live_high_r == $past(live_high_r) + 8'h01;
  endproperty
  a_carry: assert property (p_carry) else $error("no carry to high");

  // a bypassed prescaler sits at zero
  property p_bypass_clr;
    @(posedge pclk) disable iff (!presetn)
      ctrl_r.bypass |=> presc_r == 8'h00;
  endproperty
  a_bypass_clr: assert property (p_bypass_clr) else $error("prescaler moved in bypass");

  // prescaler holds while counting is inactive
  property p_presc_idle;
    @(posedge pclk) disable iff (!presetn)
      !active && !wr_low && !ctrl_r.bypass |=> presc_r == $past(presc_r);
  endproperty
  a_presc_idle: assert property (p_presc_idle) else $error("prescaler moved idle");

  // sleep freezes the prescaler as well
  property p_sleep_presc;
    @(posedge pclk) disable iff (!presetn)
      sleep && !wr_low && !ctrl_r.bypass |=> presc_r == $past(presc_r);
  endproperty
  a_sleep_presc: assert property (p_sleep_presc) else $error("prescaler in sleep");

  // counter mode needs a pin edge to count
  property p_ext_quiet;
    @(posedge pclk) disable iff (!presetn)
      ctrl_r.ext_src && !rise && !fall |-> !inc;
  endproperty
  a_ext_quiet: assert property (p_ext_quiet) else $error("count with no edge");

  // a pin rise walks down the synchroniser one stage per cycle
  sequence s_sync_follow;
    $rose(sync2_r) ##1 $rose(sync3_r);
  endsequence

  property p_sync_chain;
    @(posedge pclk) disable iff (!presetn)
      $rose(sync1_r) |=> s_sync_follow;
  endproperty
  a_sync_chain: assert property (p_sync_chain) else $error("synchroniser skipped");

  // the device never clears the flag by itself
  property p_flag_keep;
    @(posedge pclk) disable iff (!presetn)
      flag_r && !(wr && hit_irq) |=> flag_r;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag dropped");

  // a set flag with the mask on raises the request
  property p_irq_on;
    @(posedge pclk) disable iff (!presetn)
      mask_r && flag_r |=> irq_r;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");

  // no request without a flag or a wrap
  property p_no_early_irq;
    @(posedge pclk) disable iff (!presetn)
      !flag_r && !wrap |=> !irq_r;
  endproperty
  a_no_early_irq: assert property (p_no_early_irq) else $error("irq without flag");

  // a wrap always lands on zero
  property p_wrap_zero;
    @(posedge pclk) disable iff (!presetn)
      wrap && !wr_low |=> low_r == 8'h00;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("wrap not zero");

  // low reads in 8-bit mode leave the buffer alone
  property p_snap8;
    @(posedge pclk) disable iff (!presetn)
      rd_low && ctrl_r.width8 |=> high_buf_r == $past(high_buf_r);
  endproperty
  a_snap8: assert property (p_snap8) else $error("buffer moved in 8-bit");

  // control writes take the whole byte
  property p_ctrl_write;
    @(posedge pclk) disable iff (!presetn)
      wr && hit_ctrl |=> ctrl_r == $past(pwdata[7:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  // buffer writes land in the buffer only
  property p_buf_write;
    @(posedge pclk) disable iff (!presetn)
      wr && hit_high |=> high_buf_r == $past(pwdata[7:0]);
  endproperty
  a_buf_write: assert property (p_buf_write) else $error("buffer write lost");

  // high reads return the buffer, never the live byte
  property p_read_high;
    @(posedge pclk) disable iff (!presetn)
      rd && hit_high |=> prdata_r == {24'h00_0000, $past(high_buf_r)};
  endproperty
  a_read_high: assert property (p_read_high) else $error("high read wrong");

  // ready is a single-cycle pulse
  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready_r |=> !pready_r;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");

  // error only ever rides with ready
  property p_err_ready;
    @(posedge pclk) disable iff (!presetn)
      pslverr_r |-> pready_r;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");

  // unmapped reads return zero
  property p_unmapped_read;
    @(posedge pclk) disable iff (!presetn)
      rd && !mapped |=> prdata_r == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read data");
endmodule

// ### verif/count_source.sv
`timescale 1ns/1ps
// far-side count source; each level is held at least 5 clocks so the 2-stage sync sees it
module count_source (
  input  wire logic pclk,
  output logic      pin
);
  initial pin = 1'b0;
  // one level change, held long enough for synchronising
  task automatic level(input logic v);
    @(posedge pclk);
    pin <= v;
    repeat (4) @(posedge pclk);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      level(1'b1);
      level(1'b0);
    end
  endtask
endmodule

// ### verif/eight_sixteen_bit_timer_prescaled_tb.sv
`timescale 1ns/1ps
module eight_sixteen_bit_timer_prescaled_tb;
  import timer_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  v;
  } row_s;
  logic        pclk, presetn, psel, penable, pwrite, sleep;
  logic        pready, pslverr, overflow_irq, pin, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          errors, n_checks;
  // reset values of the register map
  row_s        rows [3] = '{{ctrl_addr, ctrl_reset}, {high_addr, high_reset}, {irq_addr, 8'h00}};

  timer_counter u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_pin(pin), .sleep(sleep), .overflow_irq(overflow_irq));
  count_source u_src (.pclk(pclk), .pin(pin));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // one apb transfer; an idle cycle follows so the next setup never collides
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk("register read", {24'h00_0000, e}, rd);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog; the prescaler sweep dominates at about 5000 cycles
  initial begin
    repeat (30000) @(posedge pclk);
    errors++;
    report_and_stop();
  end

  initial begin
    {presetn, psel, penable, pwrite, sleep} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) rdchk(rows[i].a, rows[i].v);
    apb(1'b0, 12'h010, 8'h00);
    chk("pslverr", 32'(slv), 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
    $display("reset rows done");
    // stopped timer holds; low byte survives a later reset
    wr(ctrl_addr, 8'h08);
    wr(low_addr, 8'h5a);
    rdchk(low_addr, 8'h5a);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(low_addr, 8'h5a);
    rdchk(high_addr, 8'h00);
    rdchk(ctrl_addr, 8'hff);
    $display("second reset done");
    // 16-bit buffer pairing, then a running wrap of ffff
    wr(ctrl_addr, 8'h08);
    wr(high_addr, 8'h12);
    wr(low_addr, 8'h34);
    rdchk(low_addr, 8'h34);
    rdchk(high_addr, 8'h12);
    wr(irq_addr, 8'h00);
    wr(ctrl_addr, 8'h88);
    wr(high_addr, 8'hff);
    wr(low_addr, 8'hfe);
    rdchk(low_addr, 8'hff);
    rdchk(high_addr, 8'hff);
    rdchk(low_addr, 8'h07);
    rdchk(irq_addr, 8'h01);
    $display("16-bit test done");
    // 8-bit wrap with mask set; buffer must stay untouched by low reads
    wr(irq_addr, 8'h02);
    wr(ctrl_addr, 8'hc8);
    wr(high_addr, 8'h77);
    wr(low_addr, 8'hf0);
    wr(high_addr, 8'h55);
    repeat (30) @(posedge pclk);
    chk("irq pin", 32'(overflow_irq), 32'h0000_0001);
    rdchk(irq_addr, 8'h03);
    rdchk(low_addr, 8'h17);
    rdchk(high_addr, 8'h55);
    wr(irq_addr, 8'h00);
    repeat (300) @(posedge pclk);
    chk("irq masked", 32'(overflow_irq), 32'h0000_0000);
    rdchk(irq_addr, 8'h01);
    $display("8-bit test done");
    // every ratio, switched while running; count write clears the prescaler
    for (int n = 0; n < 8; n++) begin
      wr(ctrl_addr, 8'hc0 | 8'(n));
      wr(low_addr, 8'h00);
      repeat ((2 << n) * 8 + (1 << n) - 2) @(posedge pclk);
      rdchk(low_addr, 8'h08);
    end
    $display("prescaler test done");
    // sleep freezes counting
    wr(ctrl_addr, 8'hc8);
    sleep <= 1'b1;
    wr(low_addr, 8'h10);
    repeat (20) @(posedge pclk);
    rdchk(low_addr, 8'h10);
    sleep <= 1'b0;
    $display("sleep test done");
    // external edges, rising then falling
    wr(ctrl_addr, 8'he8);
    wr(low_addr, 8'h00);
    u_src.pulses(5);
    u_src.level(1'b1);
    rdchk(low_addr, 8'h06);
    wr(ctrl_addr, 8'hf8);
    wr(low_addr, 8'h00);
    u_src.level(1'b0);
    u_src.pulses(2);
    rdchk(low_addr, 8'h03);
    $display("external count test done");
    report_and_stop();
  end
endmodule
